/* File: sim/iofs_ctrl_model.sv */
// fieldbus controller model that collects the diagnostics
`timescale 1ns/10ps
`default_nettype none
module iofs_ctrl_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        diag_valid,
    input  wire logic [15:0] diag_chan,
    input  wire logic [19:0] diag_code,
    output logic [7:0]       n_diag,
    output logic [15:0]      last_chan,
    output logic [19:0]      last_code
);
    // take each one-cycle diagnostic pulse in its own cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_diag    <= 8'h00;
            last_chan <= 16'h0000;
            last_code <= 20'h00000;
        end else if (diag_valid) begin // pulse stands one cycle only
            n_diag    <= n_diag + 8'h01;
            last_chan <= diag_chan;
            last_code <= diag_code;
        end
    end
endmodule
`default_nettype wire

/* File: sim/iofs_supervisor_tb.sv */
// self-checking bench for the fault supervisor
`timescale 1ns/10ps
`default_nettype none
module iofs_supervisor_tb;
    import iofs_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic us_low = 0, us_high = 0, ul_low = 0, ul_high = 0;
    logic aux_low = 0, aux_high = 0;
    logic [7:0] sensor_short = 0, outa_short = 0;
    wire logic hreadyout, hresp, diag_valid, irq, us_led, ul_led;
    wire logic [31:0] hrdata;
    wire logic [7:0] drv, pfi, n_diag;
    wire logic [15:0] diag_chan, last_chan;
    wire logic [19:0] diag_code, last_code;
    int failures = 0, n_checks = 0;
    // short ms so the long counts finish quickly
    iofs_supervisor #(.MS_CYCLES(10)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .us_low(us_low), .us_high(us_high), .ul_low(ul_low),
        .ul_high(ul_high), .aux_low(aux_low), .aux_high(aux_high),
        .sensor_short(sensor_short), .outa_short(outa_short),
        .outa_drive(drv), .us_led_red(us_led), .ul_led_red(ul_led),
        .port_fault_indicator(pfi), .diag_valid(diag_valid),
        .diag_chan(diag_chan), .diag_code(diag_code), .irq(irq));
    iofs_ctrl_model u_ctrl (.hclk(hclk), .hresetn(hresetn),
        .diag_valid(diag_valid), .diag_chan(diag_chan),
        .diag_code(diag_code), .n_diag(n_diag), .last_chan(last_chan),
        .last_code(last_code));
    // 100 mhz clock
    initial begin
        forever #5 hclk = ~hclk;
    end
    // compare and count
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one ahb-lite transfer; read data taken at the data phase edge
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        xfer(1, a, d, r);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
        logic [31:0] r;
        xfer(0, a, 32'h0, r);
        chk(nm, e, r);
        chk("hresp", 0, hresp); // okay response on every read
    endtask
    // diagnostic count and last channel and code
    task automatic dg(int n, logic [15:0] c, logic [19:0] k);
        repeat (40) @(posedge hclk);
        chk("n_diag", n, n_diag);
        chk("chan", c, last_chan);
        chk("code", k, last_code);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #300000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        rd(A_ALARM_EN, 32'h0, "alarm_en");
        rd(A_FILTER, 32'h50, "filter");
        rd(8'h40, 32'h0, "unmapped");
        $display("test reset done");
        us_low <= 1; // raised even with alarms off
        dg(1, CHAN_GLOBAL, CODE_US);
        chk("us_led off", 0, us_led);
        wr(A_ALARM_EN, 32'h1);
        repeat (3) @(posedge hclk);
        chk("us_led red", 1, us_led);
        dg(1, CHAN_GLOBAL, CODE_US);
        wr(A_IRQ_MASK, 32'h1);
        @(posedge hclk); // mask lands at the edge ending the write
        chk("irq set", 1, irq);
        rd(A_IRQ_STAT, 32'h1, "irq_stat");
        chk("irq clear", 0, irq);
        $display("test system supply done");
        ul_low <= 1; // alarm still disabled
        dg(1, CHAN_GLOBAL, CODE_US);
        chk("ul_led off", 0, ul_led);
        ul_low <= 0;
        wr(A_ALARM_EN, 32'h7);
        rd(A_ALARM_EN, 32'h7, "alarm_en set");
        ul_high <= 1;
        dg(2, CHAN_GLOBAL, CODE_UL);
        aux_low <= 1;
        dg(3, CHAN_GLOBAL, CODE_AUX);
        chk("ul_led aux", 1, ul_led);
        {ul_high, aux_low, us_low} <= 3'h0;
        $display("test actuator supplies done");
        sensor_short[2] <= 1;
        dg(4, 16'h0003, CODE_SENSOR);
        chk("pfi port3", 1, pfi[2]);
        sensor_short <= 0;
        $display("test sensor short done");
        // port1 auto restart, port2 restart after reset, no filter
        wr(A_FILTER, 32'h0);
        wr(A_IO_MODE, 32'hff);
        wr(A_RESTART, 32'h2);
        wr(A_OUT_CMD, 32'h3);
        repeat (3) @(posedge hclk);
        chk("drive on", 2'h3, drv[1:0]);
        outa_short <= 8'h03;
        dg(6, 16'h0002, CODE_OUTA);
        chk("drive off", 2'h0, drv[1:0]);
        outa_short <= 0;
        repeat (1100) @(posedge hclk);
        chk("auto retry", 1, drv[0]);
        chk("held off", 0, drv[1]);
        wr(A_OUT_CMD, 32'h1); // controller writes low first
        wr(A_OUT_CMD, 32'h3);
        repeat (3) @(posedge hclk);
        chk("restarted", 1, drv[1]);
        $display("test restart done");
        // port3 turns on into a standing short under the 80 ms filter
        wr(A_FILTER, 32'h50);
        outa_short <= 8'h04;
        wr(A_OUT_CMD, 32'h7);
        repeat (600) @(posedge hclk);
        chk("filtered", 1, drv[2]);
        repeat (400) @(posedge hclk);
        chk("filter out", 0, drv[2]);
        chk("pfi quiet", 2'h0, pfi[1:0]);
        ul_low <= 1;
        repeat (40) @(posedge hclk);
        chk("pfi active", 2'h3, pfi[1:0]);
        us_high <= 1; // over range re-enters the system fault
        dg(9, CHAN_GLOBAL, CODE_US);
        $display("test filter and supply loss done");
        complete_run();
    end
endmodule
`default_nettype wire

/* File: src/iofs_pkg.sv */
// constants and types shared by the i/o master fault supervisor
`default_nettype none
package iofs_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ    = 100_000_000; // hclk rate in hz
    localparam int unsigned MS_PER_S  = 1000;        // ms in one second
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S; // cycles per ms
    localparam int unsigned NPORTS    = 8;           // i/o ports
    localparam int unsigned EV_W      = 24;          // event vector width

    // turn-on filter and retry time, in ms
    localparam logic [7:0] FILTER_RST = 8'h50;       // 80 ms after reset
    localparam logic [7:0] RETRY_MS   = 8'h64;       // 100 ms off on retry

    // register byte offsets
    localparam logic [7:0] A_ALARM_EN  = 8'h00;      // supply alarm enables
    localparam logic [7:0] A_RESTART   = 8'h04;      // restart policy/port
    localparam logic [7:0] A_FILTER    = 8'h08;      // turn-on filter ms
    localparam logic [7:0] A_OUT_CMD   = 8'h0c;      // commanded outputs
    localparam logic [7:0] A_IO_MODE   = 8'h10;      // digital_io_mode
    localparam logic [7:0] A_SUPPLY_ST = 8'h14;      // live supply faults
    localparam logic [7:0] A_PORT_ST   = 8'h18;      // live port faults
    localparam logic [7:0] A_IRQ_STAT  = 8'h1c;      // sticky events
    localparam logic [7:0] A_IRQ_MASK  = 8'h20;      // interrupt mask
    localparam logic [7:0] A_DIAG_CHAN = 8'h24;      // last channel number
    localparam logic [7:0] A_DIAG_CODE = 8'h28;      // last diagnostic code

    // alarm enable field positions
    localparam int unsigned EN_US  = 0;              // system/sensor supply
    localparam int unsigned EN_UL  = 1;              // actuator supply
    localparam int unsigned EN_AUX = 2;              // auxiliary supply

    // event vector layout, shared by irq status, mask and diagnostics
    localparam int unsigned EV_US     = 0;           // system supply
    localparam int unsigned EV_UL     = 1;           // actuator supply
    localparam int unsigned EV_AUX    = 2;           // auxiliary supply
    localparam int unsigned EV_SENSOR = 8;           // sensor short 8..15
    localparam int unsigned EV_OUTA   = 16;          // output fault 16..23

    // diagnostic channel numbers and codes
    localparam logic [15:0] CHAN_GLOBAL = 16'h8000;  // not channel-specific
    localparam logic [19:0] CODE_US     = 20'h00002; // undervoltage
    localparam logic [19:0] CODE_UL     = 20'h00118; // actuator supply
    localparam logic [19:0] CODE_AUX    = 20'h0180e; // auxiliary supply
    localparam logic [19:0] CODE_SENSOR = 20'h01806; // short at sensor supply
    localparam logic [19:0] CODE_OUTA   = 20'h01811; // short at channel a

    // per-port output state, gray along active-retry-active
    typedef enum logic [1:0] {
        PST_ACTIVE = 2'b00,
        PST_RETRY  = 2'b01,
        PST_LATCH  = 2'b10
    } iofs_port_st_t;
endpackage
`default_nettype wire

/* File: src/iofs_supervisor.sv */
// fault supervisor for an eight-port i/o master, with ahb-lite registers
//
// What this block does
// - flag system supply outside 18..30 V
// - system supply fault reports 0x8000, code 0x0002
// - system indicator red only when alarms enabled
// - actuator supplies fault only when alarm enabled
// - actuator alarm enables reset disabled, software settable
// - actuator supply fault reports 0x8000, code 0x0118
// - auxiliary supply fault reports 0x8000, code 0x0180e
// - shared actuator indicator red when enabled supply drops below range
// - failed actuator supply flags every active output
// - sensor supply short reports code 0x1806, channel 1..8
// - port indicator lit on any port error
// - auto policy: faulted output off, retried cyclically
// - reset policy: output off until commanded low
// - turn-on filter hides errors 0..255 ms
// - channel a output short reports code 0x1811
// - reset-policy outputs restart only after controller commands inactive
`timescale 1ns/10ps
`default_nettype none
module iofs_supervisor #(
    parameter int unsigned MS_CYCLES = iofs_pkg::MS_CYCLES // cycles per ms
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    input  wire logic                          us_low,
    input  wire logic                          us_high,
    input  wire logic                          ul_low,
    input  wire logic                          ul_high,
    input  wire logic                          aux_low,
    input  wire logic                          aux_high,
    input  wire logic [iofs_pkg::NPORTS-1:0]   sensor_short,
    input  wire logic [iofs_pkg::NPORTS-1:0]   outa_short,
    output logic [iofs_pkg::NPORTS-1:0]        outa_drive,
    output logic                               us_led_red,
    output logic                               ul_led_red,
    output logic [iofs_pkg::NPORTS-1:0]        port_fault_indicator,
    output logic                               diag_valid,
    output logic [15:0]                        diag_chan,
    output logic [19:0]                        diag_code,
    output logic                               irq
);
    import iofs_pkg::*;

    // software-visible configuration
    logic [2:0]        alarm_en_reg;   // supply alarm enables
    logic [7:0]        restart_reg;    // 1 = restart after output reset
    logic [7:0]        filter_reg;     // turn-on filter in ms
    logic [7:0]        out_cmd_reg;    // commanded channel a outputs
    logic [7:0]        io_mode_reg;    // 1 = port is a digital output
    logic [EV_W-1:0]   irq_stat_reg;   // sticky event bits
    logic [EV_W-1:0]   irq_mask_reg;   // 1 = event may raise irq

    // bus pipeline
    logic              wr_pend_reg;    // write data phase pending
    logic [7:0]        wr_addr_reg;    // write offset latched
    logic [31:0]       hrdata_reg;     // read data for the data phase

    // fault tracking
    logic [EV_W-1:0]   cond_reg;       // fault conditions last cycle
    logic [EV_W-1:0]   pend_reg;       // diagnostics waiting to go out
    logic              diag_valid_reg; // one-cycle diagnostic strobe
    logic [15:0]       diag_chan_reg;  // channel of last diagnostic
    logic [19:0]       diag_code_reg;  // code of last diagnostic
    logic              us_led_reg;     // system supply indicator
    logic              ul_led_reg;     // actuator supply indicator
    logic [7:0]        port_ind_reg;   // port fault indicators
    logic [7:0]        drive_reg;      // channel a outputs driven
    logic [16:0]       pre_reg;        // ms prescaler

    // per-port output control
    iofs_port_st_t     pst_reg  [NPORTS];  // output restart state
    logic [7:0]        filt_reg [NPORTS];  // filter ms remaining
    logic [7:0]        retry_reg[NPORTS];  // retry ms remaining

    // ahb-lite decode
    wire         acc      = hsel & htrans[1] & hready;   // accepted transfer
    wire         rd_acc   = acc & ~hwrite;               // accepted read
    wire [7:0]   ra       = haddr[7:0];                  // read offset
    wire         stat_clr = rd_acc & (ra == A_IRQ_STAT); // clear on read
    wire         wr_en    = wr_pend_reg;                 // data-phase write

    // supply fault conditions
    wire us_fault  = us_low | us_high;
    wire ul_fault  = alarm_en_reg[EN_UL] & (ul_low | ul_high);
    wire aux_fault = alarm_en_reg[EN_AUX] & (aux_low | aux_high);
    wire act_fail  = ul_fault | aux_fault;               // actuator failure
    wire ms_tick   = (pre_reg == 17'(MS_CYCLES - 1));    // one ms elapsed

    // per-port derived terms
    logic [7:0]  outa_off;       // output held off by a fault
    logic [7:0]  outa_qual;      // short seen outside the filter window
    logic [7:0]  drive_next;     // next channel a drive
    logic [7:0]  port_err;       // any error on the port

    // event conditions and rising edges
    wire [EV_W-1:0] cond_now = {outa_off, sensor_short,
                                5'h00, aux_fault, ul_fault, us_fault};
    wire [EV_W-1:0] rise     = cond_now & ~cond_reg;
    wire [EV_W-1:0] grant    = pend_reg & (~pend_reg + 24'h000001);

    // lowest pending source becomes channel and code
    function automatic logic [35:0] iofs_encode(input logic [EV_W-1:0] g);
        logic [35:0] r;
        r = 36'h000000000;
        for (int i = 0; i < EV_W; i++) begin
            if (g[i]) begin
                if (i == EV_US) begin
                    r = {CHAN_GLOBAL, CODE_US};
                end else if (i == EV_UL) begin
                    r = {CHAN_GLOBAL, CODE_UL};
                end else if (i == EV_AUX) begin
                    r = {CHAN_GLOBAL, CODE_AUX};
                end else if (i >= EV_OUTA) begin
                    r = {16'(i - EV_OUTA + 1), CODE_OUTA};
                end else if (i >= EV_SENSOR) begin
                    r = {16'(i - EV_SENSOR + 1), CODE_SENSOR};
                end
            end
        end
        return r;
    endfunction

    wire [35:0] enc = iofs_encode(grant);

    // read multiplexer, unmapped offsets read zero
    wire [31:0] rmux =
        (ra == A_ALARM_EN)  ? {29'h0, alarm_en_reg} :
        (ra == A_RESTART)   ? {24'h0, restart_reg} :
        (ra == A_FILTER)    ? {24'h0, filter_reg} :
        (ra == A_OUT_CMD)   ? {24'h0, out_cmd_reg} :
        (ra == A_IO_MODE)   ? {24'h0, io_mode_reg} :
        (ra == A_SUPPLY_ST) ? {29'h0, aux_fault, ul_fault, us_fault} :
        (ra == A_PORT_ST)   ? {16'h0, outa_off, port_err} :
        (ra == A_IRQ_STAT)  ? {8'h0, irq_stat_reg} :
        (ra == A_IRQ_MASK)  ? {8'h0, irq_mask_reg} :
        (ra == A_DIAG_CHAN) ? {16'h0, diag_chan_reg} :
        (ra == A_DIAG_CODE) ? {12'h0, diag_code_reg} :
                              32'h00000000;

    // bus outputs: zero wait states, always okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_reg;
    assign outa_drive = drive_reg;
    assign us_led_red = us_led_reg;
    assign ul_led_red = ul_led_reg;
    assign port_fault_indicator = port_ind_reg;
    assign diag_valid = diag_valid_reg;
    assign diag_chan  = diag_chan_reg;
    assign diag_code  = diag_code_reg;
    // level interrupt while any unmasked event stays latched
    assign irq        = |(irq_stat_reg & irq_mask_reg);

    // address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h00000000;
        end else begin
            wr_pend_reg <= acc & hwrite;
            wr_addr_reg <= ra;
            hrdata_reg  <= rd_acc ? rmux : 32'h00000000;
        end
    end

    // configuration writes; enables start disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_en_reg <= 3'h0;
            restart_reg  <= 8'h00;  // automatic restart by default
            filter_reg   <= FILTER_RST;
            out_cmd_reg  <= 8'h00;
            io_mode_reg  <= 8'h00;
            irq_mask_reg <= 24'h000000;
        end else if (wr_en) begin
            if (wr_addr_reg == A_ALARM_EN) begin
                alarm_en_reg <= hwdata[2:0];
            end else if (wr_addr_reg == A_RESTART) begin
                restart_reg <= hwdata[7:0];
            end else if (wr_addr_reg == A_FILTER) begin
                filter_reg <= hwdata[7:0];
            end else if (wr_addr_reg == A_OUT_CMD) begin
                out_cmd_reg <= hwdata[7:0];
            end else if (wr_addr_reg == A_IO_MODE) begin
                io_mode_reg <= hwdata[7:0];
            end else if (wr_addr_reg == A_IRQ_MASK) begin
                irq_mask_reg <= hwdata[EV_W-1:0];
            end
        end
    end

    // sticky events; a new event beats a clearing read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= 24'h000000;
        end else begin
            irq_stat_reg <= (stat_clr ? 24'h000000 : irq_stat_reg) | rise;
        end
    end

    // diagnostics queue: one entry per source, one report per cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_reg       <= 24'h000000;
            pend_reg       <= 24'h000000;
            diag_valid_reg <= 1'b0;
            diag_chan_reg  <= 16'h0000;
            diag_code_reg  <= 20'h00000;
        end else begin
            cond_reg       <= cond_now;
            pend_reg       <= (pend_reg & ~grant) | rise;
            diag_valid_reg <= |pend_reg;
            if (|pend_reg) begin
                diag_chan_reg <= enc[35:20];
                diag_code_reg <= enc[19:0];
            end
        end
    end

    // indicators; system supply red only below range with alarms on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us_led_reg   <= 1'b0;
            ul_led_reg   <= 1'b0;
            port_ind_reg <= 8'h00;
            drive_reg    <= 8'h00;
        end else begin
            us_led_reg   <= alarm_en_reg[EN_US] & us_low;
            ul_led_reg   <= (alarm_en_reg[EN_UL] & ul_low) |
                            (alarm_en_reg[EN_AUX] & aux_low);
            port_ind_reg <= port_err;
            drive_reg    <= drive_next;
        end
    end

    // shared millisecond prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 17'h00000;
        end else begin
            pre_reg <= ms_tick ? 17'h00000 : pre_reg + 17'h00001;
        end
    end

    // per-port output supervision
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        // a short only counts while driven and out of the filter window
        assign outa_qual[p]  = outa_short[p] & drive_reg[p] &
                               (filt_reg[p] == 8'h00);
        assign outa_off[p]   = (pst_reg[p] != PST_ACTIVE);
        assign drive_next[p] = out_cmd_reg[p] & io_mode_reg[p] &
                               (pst_reg[p] == PST_ACTIVE) &
                               ~(outa_qual[p]);
        // actuator supply failure marks every active output as faulty
        assign port_err[p]   = sensor_short[p] | outa_off[p] |
                               (act_fail & drive_reg[p]);

        // turn-on filter reloads on each rising edge of the drive
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                filt_reg[p] <= 8'h00;
            end else if (drive_next[p] & ~drive_reg[p]) begin
                filt_reg[p] <= filter_reg;
            end else if (ms_tick && filt_reg[p] != 8'h00) begin
                filt_reg[p] <= filt_reg[p] - 8'h01;
            end
        end

        // restart policy: timed retry or latch until commanded low
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pst_reg[p]   <= PST_ACTIVE;
                retry_reg[p] <= 8'h00;
            end else begin
                case (pst_reg[p])
                    PST_ACTIVE: begin
                        if (outa_qual[p] && restart_reg[p]) begin
                            pst_reg[p] <= PST_LATCH;
                        end else if (outa_qual[p]) begin
                            pst_reg[p]   <= PST_RETRY;
                            retry_reg[p] <= RETRY_MS;
                        end
                    end
                    PST_RETRY: begin
                        // output off until the retry time runs out
                        if (retry_reg[p] == 8'h00) begin
                            pst_reg[p] <= PST_ACTIVE;
                        end else if (ms_tick) begin
                            retry_reg[p] <= retry_reg[p] - 8'h01;
                        end
                    end
                    PST_LATCH: begin
                        // controller must write the output low first
                        if (!out_cmd_reg[p]) begin
                            pst_reg[p] <= PST_ACTIVE;
                        end
                    end
                    default: begin
                        pst_reg[p] <= PST_ACTIVE;
                    end
                endcase
            end
        end

        // a latched output never drives while still commanded high
        a_latch_holds_off: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (pst_reg[p] == PST_LATCH && out_cmd_reg[p]) |=> !drive_reg[p])
            else $error("latched output drove while commanded high");

        // a short inside the filter window never stops the output
        a_filter_hides: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (filt_reg[p] != 8'h00 && pst_reg[p] == PST_ACTIVE)
                |=> pst_reg[p] == PST_ACTIVE)
            else $error("output faulted inside turn-on filter");

        // a sensor short lights the port indicator next cycle
        a_port_ind_on: assert property (
            @(posedge hclk) disable iff (!hresetn)
            sensor_short[p] |=> port_fault_indicator[p])
            else $error("port indicator dark on sensor short");

        // automatic policy returns the output to active in time
        a_retry_returns: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (pst_reg[p] == PST_RETRY && retry_reg[p] == 8'h00)
                |=> pst_reg[p] == PST_ACTIVE)
            else $error("retry did not return output to active");
    end

    // system supply fault is reported with its code in bounded time
    a_us_diag_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(us_fault) |-> ##[1:26] (diag_valid &&
            diag_chan == CHAN_GLOBAL && diag_code == CODE_US))
        else $error("system supply diagnostic missing");

    // actuator supply fault never flagged with its alarms off
    a_ul_gated: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!alarm_en_reg[EN_UL] && !alarm_en_reg[EN_AUX]) |-> !act_fail)
        else $error("actuator fault with alarms disabled");

    // system supply indicator follows enable and low level
    a_us_led: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (us_low && !alarm_en_reg[EN_US]) |=> !us_led_red)
        else $error("system indicator red with alarms off");

    // shared actuator indicator red for an enabled auxiliary drop
    a_aux_led: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (aux_low && alarm_en_reg[EN_AUX]) |=> ul_led_red)
        else $error("actuator indicator dark on auxiliary drop");

    // sensor diagnostics carry a port channel number 1..8
    a_sensor_chan: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (diag_valid && diag_code == CODE_SENSOR)
            |-> (diag_chan >= 16'h0001 && diag_chan <= 16'h0008))
        else $error("sensor diagnostic channel out of range");

    // a persisting actuator supply fault is reported once, not twice in a row
    a_once_per_entry: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (diag_valid && diag_code == CODE_UL)
            |=> !(diag_valid && diag_code == CODE_UL))
        else $error("actuator diagnostic repeated");
endmodule
`default_nettype wire
